// [rtl/hs_fault_protect.sv]
// Fault protection of a two-channel high-side switch: over-temperature,
// overcurrent profile with duration counter, short-circuit latch,
// auto-retry, fault pin and read-to-clear fault flags over APB.
// Assumes analog comparator outputs and direct inputs are asynchronous
// levels, and that the short comparator only fires near turn-on.
`include "hs_fault_params.svh"
// Functional notes
// - Hot channel that is on turns off, sets its temperature flag, fault low.
// - Hot channel that is off only pulls the fault output low.
// - Fault output rises after both channels cool and a channel turns on.
// - With auto-retry, a cooled channel turns back on by itself.
// - Temperature flag clears on fault read, if cool and fault output high.
// - Overcurrent turns channel off, sets its flag, pulls fault low.
// - Overcurrent is a threshold crossing or too long in a window.
// - While a window is active, sensing is blanked and sync reads one.
// - Profile is the pin level, inverted when the software bit is set.
// - After reset the profile follows the pin alone.
// - Reported profile bit is the effective selection.
// - Pin low means lighting profile, high means DC motor profile.
// - Lighting: high, middle, low thresholds, two windows of two widths.
// - Lighting profile restarts each turn-on, only once in switch mode.
// - Motor: one window opened above low threshold, selectable width.
// - With auto-retry, latching waits until retries are used up.
// - Switch mode means pulsed request faster than minimum PWM rate.
// - In switch mode counter runs only during on-time.
// - Counter clears on delatch, and at auto-retry in lighting mode.
// - Outside switch mode, motor mode clears counter at turn-off after a clean on-period.
// - In switch mode PWM toggling clears the counter only at the first lighting turn-on.
// - Short at turn-on switches off at once, sets flag, retries or latches like overcurrent.
module hs_fault_protect (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog comparators, one bit per channel
  input wire logic [1:0] overTempIn,
  input wire logic [1:0] curHighIn,
  input wire logic [1:0] curMidIn,
  input wire logic [1:0] curLowIn,
  input wire logic [1:0] shortIn,
  // Pins
  input wire logic [1:0] directOnIn,
  input wire logic [1:0] profile_select_pin,
  // Outputs
  output logic [1:0] channelOn,
  output logic fault_out_n,
  output logic [1:0] senseSync
);
  import hs_fault_pkg::*;

  logic [13:0] syncBus;
  logic [1:0] hot, curHigh, curMid, curLow, shortDet, dirOn, profPin;

  sync_2ff #(.W(14)) u_sync (
    .clock(clock),
    .rst(rst),
    .asyncIn({profile_select_pin, directOnIn, shortIn, curLowIn,
              curMidIn, curHighIn, overTempIn}),
    .syncOut(syncBus)
  );
  assign hot = syncBus[1:0];
  assign curHigh = syncBus[3:2];
  assign curMid = syncBus[5:4];
  assign curLow = syncBus[7:6];
  assign shortDet = syncBus[9:8];
  assign dirOn = syncBus[11:10];
  assign profPin = syncBus[13:12];

  // Register bus
  logic pready_ff, pslverr_ff;
  logic [31:0] prdata_ff;
  logic [1:0] swOn_ff, retryEn_ff, invert_ff, ochSel_ff, ocmSel_ff;
  logic [1:0] delatch_ff;
  logic [`CTRL_RETRY_MAX_W-1:0] retryMax_ff;
  logic [7:0] fltCap_ff;
  logic acc, faultRead;
  logic [7:0] faultVec;
  logic [1:0] ocFlag_ff, scFlag_ff, otFlag_ff, latched_ff, retryWait_ff;
  logic [1:0] otOff_ff, chOn_ff, chOnPrev_ff, swMode_ff, window_ff;
  logic [1:0] prof, onRise;
  logic otPend_ff, faultN_ff;

  // Two-cycle access: pready rises in the second access cycle
  assign acc = psel && penable && pready_ff;
  assign faultRead = acc && !pwrite && (paddr == `REG_FAULT);

  always_ff @(posedge clock) begin
    if (rst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
      fltCap_ff <= 8'h0;
    end else begin
      pready_ff <= psel && penable && !pready_ff;
      if (psel && penable && !pready_ff) begin
        pslverr_ff <= !((paddr == `REG_CTRL) || (paddr == `REG_FAULT) ||
                        (paddr == `REG_STATUS));
        prdata_ff <= 32'h0;
        fltCap_ff <= 8'h0;
        if (!pwrite) begin
          case (paddr)
            `REG_CTRL: begin
              prdata_ff[`CTRL_ON_LSB +: 2] <= swOn_ff;
              prdata_ff[`CTRL_RETRY_EN_LSB +: 2] <= retryEn_ff;
              prdata_ff[`CTRL_INVERT_LSB +: 2] <= invert_ff;
              prdata_ff[`CTRL_OCH_SEL_LSB +: 2] <= ochSel_ff;
              prdata_ff[`CTRL_OCM_SEL_LSB +: 2] <= ocmSel_ff;
              prdata_ff[`CTRL_RETRY_MAX_LSB +: `CTRL_RETRY_MAX_W] <=
                retryMax_ff;
            end
            `REG_FAULT: begin
              prdata_ff[7:0] <= faultVec;
              fltCap_ff <= faultVec;
            end
            `REG_STATUS: begin
              prdata_ff[`STAT_ON_LSB +: 2] <= chOn_ff;
              prdata_ff[`STAT_LATCH_LSB +: 2] <= latched_ff;
              prdata_ff[`STAT_SWMODE_LSB +: 2] <= swMode_ff;
              prdata_ff[`STAT_WINDOW_LSB +: 2] <= window_ff;
            end
            default: begin
              prdata_ff <= 32'h0;
            end
          endcase
        end
      end
    end
  end

  // Control register; delatch bits are write-one pulses and read as zero
  always_ff @(posedge clock) begin
    if (rst) begin
      swOn_ff <= 2'b00;
      retryEn_ff <= 2'b00;
      invert_ff <= 2'b00;
      ochSel_ff <= 2'b00;
      ocmSel_ff <= 2'b00;
      retryMax_ff <= `RETRY_MAX_RESET;
      delatch_ff <= 2'b00;
    end else begin
      delatch_ff <= 2'b00;
      if (acc && pwrite && (paddr == `REG_CTRL)) begin
        swOn_ff <= pwdata[`CTRL_ON_LSB +: 2];
        retryEn_ff <= pwdata[`CTRL_RETRY_EN_LSB +: 2];
        invert_ff <= pwdata[`CTRL_INVERT_LSB +: 2];
        ochSel_ff <= pwdata[`CTRL_OCH_SEL_LSB +: 2];
        ocmSel_ff <= pwdata[`CTRL_OCM_SEL_LSB +: 2];
        retryMax_ff <= pwdata[`CTRL_RETRY_MAX_LSB +: `CTRL_RETRY_MAX_W];
        delatch_ff <= pwdata[`CTRL_DELATCH_LSB +: 2];
      end
    end
  end

  assign prof = profPin ^ invert_ff;
  assign onRise = chOn_ff & ~chOnPrev_ff;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      logic onReq, reqPrev_ff, ocEvent, scEvent, hardFault;
      logic expired, durCount, durClear, advance, started_ff, ocSeen_ff;
      logic retryDone_ff, nxt_on, win;
      logic [`DUR_W-1:0] limit, offCnt_ff, onCnt_ff;
      logic [`DUR_W-1:0] retryCnt_ff;
      logic [`CTRL_RETRY_MAX_W-1:0] retryLeft_ff;
      prof_phase_t phase_ff;

      assign onReq = swOn_ff[g] | dirOn[g];

      // A short on-off cycle means pulsed drive; a long steady level ends it
      always_ff @(posedge clock) begin
        if (rst) begin
          reqPrev_ff <= 1'b0;
          offCnt_ff <= `DUR_W'(`T_SWM_CYC);
          onCnt_ff <= '0;
          swMode_ff[g] <= 1'b0;
        end else begin
          reqPrev_ff <= onReq;
          if (onReq) begin
            offCnt_ff <= '0;
            if (!reqPrev_ff) begin
              onCnt_ff <= '0;
              if (offCnt_ff < `DUR_W'(`T_SWM_CYC)) begin
                swMode_ff[g] <= 1'b1;
              end
            end else if (onCnt_ff < `DUR_W'(`T_SWM_CYC)) begin
              onCnt_ff <= onCnt_ff + 1'b1;
            end else begin
              swMode_ff[g] <= 1'b0;
            end
          end else if (offCnt_ff < `DUR_W'(`T_SWM_CYC)) begin
            offCnt_ff <= offCnt_ff + 1'b1;
          end else begin
            swMode_ff[g] <= 1'b0;
          end
        end
      end

      // Window widths of the active profile and segment
      always_comb begin
        limit = '0;
        if (prof[g]) begin
          limit = ocmSel_ff[g] ? `DUR_W'(`T_OCM2_M_CYC) :
                                 `DUR_W'(`T_OCM1_M_CYC);
        end else if (phase_ff == PH_HIGH) begin
          limit = ochSel_ff[g] ? `DUR_W'(`T_OCH2_CYC) :
                                 `DUR_W'(`T_OCH1_CYC);
        end else begin
          limit = ocmSel_ff[g] ? `DUR_W'(`T_OCM2_CYC) :
                                 `DUR_W'(`T_OCM1_CYC);
        end
      end

      // Overcurrent decision of the profile engine
      always_comb begin
        ocEvent = 1'b0;
        advance = 1'b0;
        win = 1'b0;
        if (chOn_ff[g]) begin
          if (prof[g]) begin
            win = curLow[g];
            ocEvent = curHigh[g] || (curLow[g] && expired);
          end else begin
            case (phase_ff)
              PH_HIGH: begin
                win = 1'b1;
                ocEvent = curHigh[g] || (expired && curMid[g]);
                advance = expired && !curMid[g];
              end
              PH_MID: begin
                win = 1'b1;
                ocEvent = curHigh[g] || curMid[g] ||
                          (expired && curLow[g]);
                advance = expired && !curLow[g];
              end
              PH_STEADY: begin
                ocEvent = curLow[g] || curHigh[g];
              end
              default: begin
                ocEvent = curLow[g] || curHigh[g];
              end
            endcase
          end
        end
      end

      assign scEvent = chOn_ff[g] && shortDet[g];
      assign hardFault = ocEvent || scEvent;

      // Lighting stair: restarts each turn-on, under pulsed drive only the first one after reset or delatch
      always_ff @(posedge clock) begin
        if (rst || delatch_ff[g]) begin
          phase_ff <= PH_IDLE;
          started_ff <= 1'b0;
        end else if (prof[g]) begin
          phase_ff <= PH_STEADY;
        end else if (onRise[g] && (!swMode_ff[g] || !started_ff)) begin
          phase_ff <= PH_HIGH;
          started_ff <= 1'b1;
        end else if (advance) begin
          phase_ff <= (phase_ff == PH_HIGH) ? PH_MID : PH_STEADY;
        end
      end

      // Clean on-period tracking for the motor profile
      always_ff @(posedge clock) begin
        if (rst || onRise[g]) begin
          ocSeen_ff <= 1'b0;
        end else if (chOn_ff[g] && curLow[g]) begin
          ocSeen_ff <= 1'b1;
        end
      end

      // Counts only on-time inside a window, so off-times pause it
      assign durCount = win;
      assign durClear = delatch_ff[g] || advance ||
        (!prof[g] && retryDone_ff) ||
        (!prof[g] && onRise[g] && (!swMode_ff[g] || !started_ff)) ||
        (prof[g] && !swMode_ff[g] && chOnPrev_ff[g] && !chOn_ff[g] &&
         !ocSeen_ff);

      duration_counter u_dur (
        .clock(clock),
        .rst(rst),
        .clear(durClear),
        .count(durCount),
        .limit(limit),
        .expired(expired)
      );

      // Auto-retry and latch of overcurrent and short-circuit
      always_ff @(posedge clock) begin
        if (rst) begin
          latched_ff[g] <= 1'b0;
          retryWait_ff[g] <= 1'b0;
          retryCnt_ff <= '0;
          retryLeft_ff <= `RETRY_MAX_RESET;
          retryDone_ff <= 1'b0;
        end else begin
          retryDone_ff <= 1'b0;
          if (delatch_ff[g]) begin
            latched_ff[g] <= 1'b0;
            retryWait_ff[g] <= 1'b0;
            retryLeft_ff <= retryMax_ff;
          end else if (hardFault) begin
            if (retryEn_ff[g] && (retryLeft_ff != '0)) begin
              retryWait_ff[g] <= 1'b1;
              retryCnt_ff <= '0;
              retryLeft_ff <= retryLeft_ff - 1'b1;
            end else begin
              latched_ff[g] <= 1'b1;
            end
          end else if (retryWait_ff[g]) begin
            if (retryCnt_ff == `DUR_W'(`T_RETRY_CYC - 1)) begin
              retryWait_ff[g] <= 1'b0;
              retryDone_ff <= 1'b1;
            end else begin
              retryCnt_ff <= retryCnt_ff + 1'b1;
            end
          end
        end
      end

      // Thermal shutdown; without retry a fresh request is needed
      always_ff @(posedge clock) begin
        if (rst) begin
          otOff_ff[g] <= 1'b0;
        end else if (hot[g] && chOn_ff[g]) begin
          otOff_ff[g] <= 1'b1;
        end else if (!hot[g] && (retryEn_ff[g] || !onReq)) begin
          otOff_ff[g] <= 1'b0;
        end
      end

      assign nxt_on = onReq && !latched_ff[g] && !retryWait_ff[g] &&
                      !otOff_ff[g] && !hot[g] && !hardFault;

      always_ff @(posedge clock) begin
        if (rst) begin
          chOn_ff[g] <= 1'b0;
          chOnPrev_ff[g] <= 1'b0;
          window_ff[g] <= 1'b0;
        end else begin
          chOn_ff[g] <= nxt_on;
          chOnPrev_ff[g] <= chOn_ff[g];
          window_ff[g] <= win;
        end
      end

      // Flags: a set in the clearing cycle wins over the read
      always_ff @(posedge clock) begin
        if (rst) begin
          ocFlag_ff[g] <= 1'b0;
          scFlag_ff[g] <= 1'b0;
          otFlag_ff[g] <= 1'b0;
        end else begin
          if (ocEvent) begin
            ocFlag_ff[g] <= 1'b1;
          end else if (faultRead && fltCap_ff[g*`FLT_STRIDE+`FLT_OC] &&
                       !latched_ff[g]) begin
            ocFlag_ff[g] <= 1'b0;
          end
          if (scEvent) begin
            scFlag_ff[g] <= 1'b1;
          end else if (faultRead && fltCap_ff[g*`FLT_STRIDE+`FLT_SC] &&
                       !latched_ff[g]) begin
            scFlag_ff[g] <= 1'b0;
          end
          if (hot[g] && chOn_ff[g]) begin
            otFlag_ff[g] <= 1'b1;
          end else if (faultRead && fltCap_ff[g*`FLT_STRIDE+`FLT_OT] &&
                       !hot[g] && faultN_ff) begin
            otFlag_ff[g] <= 1'b0;
          end
        end
      end

      assign faultVec[g*`FLT_STRIDE+`FLT_OC] = ocFlag_ff[g];
      assign faultVec[g*`FLT_STRIDE+`FLT_SC] = scFlag_ff[g];
      assign faultVec[g*`FLT_STRIDE+`FLT_OT] = otFlag_ff[g];
      assign faultVec[g*`FLT_STRIDE+`FLT_PROF] = prof[g];
    end
  endgenerate

  // Thermal part of the fault pin, released only by a later turn-on
  always_ff @(posedge clock) begin
    if (rst) begin
      otPend_ff <= 1'b0;
    end else if (|hot) begin
      otPend_ff <= 1'b1;
    end else if (|onRise) begin
      otPend_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      faultN_ff <= 1'b1;
    end else begin
      faultN_ff <= !(otPend_ff || (|hot) || (|latched_ff) ||
                     (|retryWait_ff) || (|otOff_ff));
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign channelOn = chOn_ff;
  assign fault_out_n = faultN_ff;
  assign senseSync = window_ff;
endmodule : hs_fault_protect

// [pkg/hs_fault_params.svh]
// Offsets, field positions, reset values and timing counts of the
// two-channel fault protection block.
// Assumes a 125 MHz core clock and a 32-bit APB register bus.
`ifndef HS_FAULT_PARAMS_SVH
`define HS_FAULT_PARAMS_SVH

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_FAULT 8'h04
`define REG_STATUS 8'h08

// Control register fields, two bits each (one per channel), except the shared 4-bit retry count
`define CTRL_ON_LSB 0
`define CTRL_RETRY_EN_LSB 2
`define CTRL_INVERT_LSB 4
`define CTRL_OCH_SEL_LSB 6
`define CTRL_OCM_SEL_LSB 8
`define CTRL_DELATCH_LSB 10
`define CTRL_RETRY_MAX_LSB 12
`define CTRL_RETRY_MAX_W 4
`define RETRY_MAX_RESET 4'h3

// Fault register: four bits per channel
`define FLT_STRIDE 4
`define FLT_OC 0
`define FLT_SC 1
`define FLT_OT 2
`define FLT_PROF 3

// Status register fields, two bits each
`define STAT_ON_LSB 0
`define STAT_LATCH_LSB 2
`define STAT_SWMODE_LSB 4
`define STAT_WINDOW_LSB 6

// Timing: times in microseconds, counts derived from the clock rate
`define CLK_MHZ 125
`define DUR_W 12
`define T_OCH1_US 4
`define T_OCH2_US 8
`define T_OCM1_US 16
`define T_OCM2_US 24
`define T_OCM1_M_US 20
`define T_OCM2_M_US 32
`define T_RETRY_US 16
`define T_SWM_PERIOD_US 32
`define T_OCH1_CYC (`T_OCH1_US * `CLK_MHZ)
`define T_OCH2_CYC (`T_OCH2_US * `CLK_MHZ)
`define T_OCM1_CYC (`T_OCM1_US * `CLK_MHZ)
`define T_OCM2_CYC (`T_OCM2_US * `CLK_MHZ)
`define T_OCM1_M_CYC (`T_OCM1_M_US * `CLK_MHZ)
`define T_OCM2_M_CYC (`T_OCM2_M_US * `CLK_MHZ)
`define T_RETRY_CYC (`T_RETRY_US * `CLK_MHZ)
`define T_SWM_CYC (`T_SWM_PERIOD_US * `CLK_MHZ)

`endif

// [pkg/hs_fault_pkg.sv]
// Types shared by the fault protection block.
// Assumes nothing of its surroundings.
package hs_fault_pkg;
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_HIGH = 2'b01,
    PH_MID = 2'b10,
    PH_STEADY = 2'b11
  } prof_phase_t;
endpackage : hs_fault_pkg

// [rtl/sync_2ff.sv]
// Two-flop synchroniser for a bus of independent levels.
// Assumes each bit is a slow level from outside the clock domain.
module sync_2ff #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Levels
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge clock) begin
    if (rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= asyncIn;
      sync_ff <= meta_ff;
    end
  end

  assign syncOut = sync_ff;
endmodule : sync_2ff

// [rtl/duration_counter.sv]
// Overcurrent duration counter of one channel.
// Assumes the caller gates counting to on-time inside a window.
`include "hs_fault_params.svh"
module duration_counter (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control
  input wire logic clear,
  input wire logic count,
  input wire logic [`DUR_W-1:0] limit,
  // Result
  output logic expired
);
  logic [`DUR_W-1:0] cnt_ff;

  // Saturates so that a long stall never wraps back under the limit
  always_ff @(posedge clock) begin
    if (rst || clear) begin
      cnt_ff <= '0;
    end else if (count && (cnt_ff != '1)) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign expired = (cnt_ff > limit);
endmodule : duration_counter

// [testbench/hs_fault_monitor.sv]
// Port-level assertions for the fault protection block.
// Assumes it is bound to hs_fault_protect and sees its ports only.
module hs_fault_monitor (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // Comparators
  input wire logic [1:0] overTempIn,
  input wire logic [1:0] curHighIn,
  input wire logic [1:0] shortIn,
  // Outputs
  input wire logic [1:0] channelOn,
  input wire logic fault_out_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence s_hot0;
    overTempIn[0] [*4];
  endsequence
  sequence s_oc_trip;
    channelOn[0] && curHighIn[0] ##1 !channelOn[0];
  endsequence
  property p_ot_off;
    s_hot0 |-> !channelOn[0];
  endproperty
  a_ot_off: assert property (p_ot_off) else $error("hot channel on");
  property p_ot_fault;
    (|overTempIn) [*5] |-> !fault_out_n;
  endproperty
  a_ot_fault: assert property (p_ot_fault) else $error("hot, pin high");
  property p_oc_off;
    curHighIn[0] [*3] |-> ##[0:2] !channelOn[0];
  endproperty
  a_oc_off: assert property (p_oc_off) else $error("overcurrent kept on");
  property p_oc_fault;
    s_oc_trip |=> !fault_out_n;
  endproperty
  a_oc_fault: assert property (p_oc_fault) else $error("trip, pin high");
  property p_sc_off;
    (channelOn[0] && shortIn[0]) [*3] |-> ##[0:2] !channelOn[0];
  endproperty
  a_sc_off: assert property (p_sc_off) else $error("short kept on");
  // Depths 2 to 4 cover the synchroniser plus the pin register
  property p_rearm;
    $rose(fault_out_n) |-> !($past(overTempIn[0], 2) &&
      $past(overTempIn[0], 3) && $past(overTempIn[0], 4));
  endproperty
  a_rearm: assert property (p_rearm) else $error("pin rose while hot");
  property p_ready;
    psel && penable && !pready |=> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("ready late");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
endmodule : hs_fault_monitor

// [testbench/host_model.sv]
// APB master standing in for the host that reads the fault flags.
// Assumes callers enter just after a rising edge, one transfer at once.
module host_model (
  // Clock
  input wire logic clock,
  // APB
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic wr, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines show the inverse so stale values are never trusted
    paddr <= ~a;
    pwdata <= ~wd;
    @(posedge clock);
  endtask : xfer
endmodule : host_model

// [testbench/tb_top.sv]
// Self-checking bench for the fault protection block.
// Assumes the host model drives APB; comparator pins are driven here.
`include "hs_fault_params.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, fault_out_n, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] overTempIn = '0, curHighIn = '0, curMidIn = '0;
  logic [1:0] curLowIn = '0, shortIn = '0, directOnIn = '0;
  logic [1:0] profile_select_pin = 2'b10;
  logic [1:0] channelOn, senseSync;
  int errors = 0, checks_done = 0;
  always #4 clock = ~clock;
  hs_fault_protect hs_fault_protect_i (.clock, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .overTempIn,
    .curHighIn, .curMidIn, .curLowIn, .shortIn, .directOnIn,
    .profile_select_pin, .channelOn, .fault_out_n, .senseSync);
  host_model host_model_i (.clock, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr);
  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_model_i.xfer(1'b1, a, d, rd, err);
  endtask : wr
  task automatic rdf(input logic [7:0] a);
    host_model_i.xfer(1'b0, a, 32'h0, rd, err);
  endtask : rdf
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  task automatic s_profile;
    rdf(`REG_FAULT);
    check("profile", rd & 32'h88, 32'h80);
    wr(`REG_CTRL, 32'h30);
    rdf(`REG_FAULT);
    check("profile inverted", rd & 32'h88, 32'h08);
    wr(`REG_CTRL, 32'h0);
    rdf(8'h0c);
    check("unmapped error", 32'(err), 32'h1);
  endtask : s_profile
  task automatic s_ot_on(input logic [31:0] ctrl);
    wr(`REG_CTRL, ctrl);
    cyc(4);
    overTempIn <= 2'b01;
    cyc(6);
    check("hot off", 32'(channelOn), 32'h0);
    check("hot fault", 32'(fault_out_n), 32'h0);
    overTempIn <= 2'b00;
    cyc(6);
    rdf(`REG_FAULT);
    check("hot flag", rd & 32'h4, 32'h4);
  endtask : s_ot_on
  task automatic s_ot_clear;
    s_ot_on(32'h1);
    check("pin low till on", 32'(fault_out_n), 32'h0);
    wr(`REG_CTRL, 32'h0);
    cyc(4100);
    wr(`REG_CTRL, 32'h1);
    cyc(6);
    check("pin high", 32'(fault_out_n), 32'h1);
    check("window", 32'(senseSync), 32'h1);
    rdf(`REG_FAULT);
    rdf(`REG_FAULT);
    check("hot flag cleared", rd & 32'h4, 32'h0);
    wr(`REG_CTRL, 32'h0);
  endtask : s_ot_clear
  task automatic s_ot_retry;
    s_ot_on(32'h5);
    cyc(2100);
    check("retried on", 32'(channelOn), 32'h1);
    wr(`REG_CTRL, 32'h0);
  endtask : s_ot_retry
  task automatic s_ot_off;
    overTempIn <= 2'b10;
    cyc(6);
    check("off hot pin", 32'(fault_out_n), 32'h0);
    check("off unchanged", 32'(channelOn), 32'h0);
    overTempIn <= 2'b00;
    cyc(6);
    directOnIn <= 2'b10;
    cyc(6);
    check("off pin high", 32'(fault_out_n), 32'h1);
    check("direct on", 32'(channelOn), 32'h2);
    check("motor no window", 32'(senseSync), 32'h0);
    directOnIn <= 2'b00;
  endtask : s_ot_off
  task automatic s_window;
    wr(`REG_CTRL, 32'h1);
    curMidIn <= 2'b01;
    cyc(400);
    check("mid in window", 32'(channelOn), 32'h1);
    check("mid blanked", 32'(senseSync), 32'h1);
    cyc(200);
    check("window expired", 32'(channelOn), 32'h0);
    check("window pin", 32'(fault_out_n), 32'h0);
    curMidIn <= 2'b00;
    wr(`REG_CTRL, 32'h400);
    rdf(`REG_FAULT);
    check("window flag", rd & 32'h1, 32'h1);
  endtask : s_window
  task automatic s_trip(input int kind);
    wr(`REG_CTRL, 32'h1);
    cyc(4);
    if (kind == 0) begin
      curHighIn <= 2'b01;
    end else begin
      shortIn <= 2'b01;
    end
    cyc(6);
    check("trip off", 32'(channelOn), 32'h0);
    check("trip pin", 32'(fault_out_n), 32'h0);
    curHighIn <= 2'b00;
    shortIn <= 2'b00;
    cyc(50);
    check("latched", 32'(channelOn), 32'h0);
    wr(`REG_CTRL, 32'h400);
    rdf(`REG_FAULT);
    check("trip flag", rd & 32'h3, kind ? 32'h2 : 32'h1);
    rdf(`REG_FAULT);
    check("trip flag cleared", rd & 32'h3, 32'h0);
    cyc(4);
    check("all clear pin", 32'(fault_out_n), 32'h1);
  endtask : s_trip
  initial begin
    cyc(10);
    rst <= 1'b0;
    // Input synchronisers need two edges before the pins are seen
    cyc(4);
    s_profile;
    s_ot_clear;
    cyc(4100);
    s_ot_retry;
    cyc(4100);
    s_ot_off;
    cyc(4100);
    s_window;
    cyc(4100);
    for (int k = 0; k < 2; k++) begin
      s_trip(k);
      cyc(4100);
    end
    complete_run;
  end
  initial begin
    cyc(45000);
    errors++;
    complete_run;
  end
endmodule : tb_top
bind hs_fault_protect hs_fault_monitor hs_fault_monitor_i (.clock, .rst,
  .psel, .penable, .pready, .overTempIn, .curHighIn, .shortIn, .channelOn,
  .fault_out_n);
